// ### inc/adc_serial_port_pkg.sv
// Shared constants and types for the multimode converter serial port
package adc_serial_port_pkg;

    // ==========================================================
    // Word format
    localparam int          WORD_BITS         = 16;
    localparam logic [15:0] TEST_RESTORE_WORD = 16'h4002;
    localparam logic [15:0] WORD_RESET        = 16'h0000;

    // ==========================================================
    // Interface modes, as the mode number
    localparam logic [2:0] MODE_1     = 3'h1;
    localparam logic [2:0] MODE_2     = 3'h2;
    localparam logic [2:0] MODE_3     = 3'h3;
    localparam logic [2:0] MODE_4     = 3'h4;
    localparam logic [2:0] MODE_5     = 3'h5;
    localparam logic [2:0] MODE_RESET = MODE_2;

    // ==========================================================
    // Sampled pin positions and their levels at reset
    localparam int         PIN_SCLK    = 0;
    localparam int         PIN_SYNC    = 1;
    localparam int         PIN_DIN     = 2;
    localparam int         PIN_CONV    = 3;
    localparam int         PIN_MCLK    = 4;
    localparam int         PIN_SEL_HI  = 5;
    localparam int         PIN_SEL_LO  = 6;
    localparam int         PIN_POL     = 7;
    localparam int         PIN_COUNT   = 8;
    localparam logic [7:0] PIN_RESET   = 8'h0a;

    // ==========================================================
    // Transfer sequencer
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_XFER = 3'b100
    } xfer_state_t;

endpackage

// ### inc/pin_sample_if.sv
// Carrier between the pin sampler and the serial port logic
`timescale 1ns/1ps
interface pin_sample_if #(
    parameter int W = 8
);
    logic [W-1:0] raw;
    logic [W-1:0] level;
    logic [W-1:0] rise;
    logic [W-1:0] fall;

    modport sampler (input raw, output level, output rise, output fall);
    modport user    (output raw, input level, input rise, input fall);
endinterface

// ### rtl/pin_sampler.sv
// Three-stage pin sampler with level agreement and edge pulses
`timescale 1ns/1ps
module pin_sampler #(
    parameter int         W         = 8,
    parameter logic [7:0] RESET_LVL = 8'h00
) (
    input  wire logic           core_clk_i,
    input  wire logic           resetn_i,
    pin_sample_if.sampler       pins
);

    // ==========================================================
    // Elaboration check
    initial begin
        if (W < 1 || W > 8) begin
            $error("pin_sampler width must be 1 to 8");
        end
    end

    // ==========================================================
    // Per-pin stages
    genvar g;
    generate
        for (g = 0; g < W; g++) begin : g_pin
            logic s1_reg, s2_reg, s3_reg, lvl_reg, rise_reg, fall_reg;
            logic lvl_next, rise_next, fall_next;

            // First stage feeds only the second
            always_comb begin
                lvl_next  = lvl_reg;
                rise_next = 1'b0;
                fall_next = 1'b0;
                if (s2_reg == s3_reg && s3_reg != lvl_reg) begin
                    lvl_next  = s3_reg;
                    rise_next = s3_reg;
                    fall_next = ~s3_reg;
                end
            end

            always_ff @(posedge core_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    s1_reg   <= RESET_LVL[g];
                    s2_reg   <= RESET_LVL[g];
                    s3_reg   <= RESET_LVL[g];
                    lvl_reg  <= RESET_LVL[g];
                    rise_reg <= 1'b0;
                    fall_reg <= 1'b0;
                end else begin
                    s1_reg   <= pins.raw[g];
                    s2_reg   <= s1_reg;
                    s3_reg   <= s2_reg;
                    lvl_reg  <= lvl_next;
                    rise_reg <= rise_next;
                    fall_reg <= fall_next;
                end
            end

            assign pins.level[g] = lvl_reg;
            assign pins.rise[g]  = rise_reg;
            assign pins.fall[g]  = fall_reg;
        end
    endgenerate

endmodule

// ### rtl/adc_serial_port.sv
// Multimode serial port of a sampling converter, device side
//
// Functional notes
// - Modes 1-3: edge select swaps out/in edges
// - Modes 4-5: edge select swaps out/in edges
// - Modes 4-5: sync fall presents first bit
// - Select high, clock low: sync fall gives MSB
// - Select low, clock high: sync fall gives MSB
// - Modes 1-2: sync high clears shifter; next fall restarts
// - Select pins choose modes two to five
// - Two-wire mode only via control bit
// - Host clocks modes 1-3; device drives 4-5
// - Mode 1 conversion from pin or bit
// - Mode 1 pulsed: pin outputs after 16 samples
// - Mode 1: float while sync high, 16 clocks
// - Sync tied low: direction flips every word
// - Calibration bursts hold pin direction throughout
// - Mode 2: sync fall enables output driver
// - Mode 2: float after sync rise, sample
// - Mode 3: sync fall triggers, counts 16 internally
// - Modes 4-5: sync high after 16th sample
`timescale 1ns/1ps
module adc_serial_port
    import adc_serial_port_pkg::*;
#(
    parameter int WORD_W = adc_serial_port_pkg::WORD_BITS
) (
    input  wire logic                  core_clk_i,
    input  wire logic                  resetn_i,
    input  wire logic                  interface_select_hi_i,
    input  wire logic                  interface_select_lo_i,
    input  wire logic                  polarity_i,
    input  wire logic                  two_wire_sel_i,
    input  wire logic                  conv_bit_i,
    input  wire logic                  conversion_start_n_i,
    input  wire logic                  master_clock_in_i,
    input  wire logic                  cal_read_burst_i,
    input  wire logic                  cal_write_burst_i,
    input  wire logic                  sclk_i,
    input  wire logic                  sync_n_i,
    input  wire logic                  din_i,
    input  wire logic [WORD_W-1:0]     tx_word_i,
    output logic                       sclk_o,
    output logic                       sclk_oe_o,
    output logic                       sync_n_o,
    output logic                       sync_n_oe_o,
    output logic                       din_o,
    output logic                       din_oe_o,
    output logic                       dout_o,
    output logic                       dout_oe_o,
    output logic [WORD_W-1:0]          rx_word_o,
    output logic                       rx_valid_o,
    output logic                       conv_start_o,
    output logic [2:0]                 mode_o
);
    import adc_serial_port_pkg::*;

    localparam int CW = $clog2(WORD_W + 1);
    localparam logic [CW-1:0] LAST_BIT = CW'(WORD_W - 1);

    // ==========================================================
    // Elaboration check
    initial begin
        if (WORD_W < 2 || WORD_W > 16) begin
            $error("adc_serial_port word width must be 2 to 16");
        end
    end

    // ==========================================================
    // Pin sampling
    pin_sample_if #(.W(PIN_COUNT)) pins ();

    assign pins.raw[PIN_SCLK]   = sclk_i;
    assign pins.raw[PIN_SYNC]   = sync_n_i;
    assign pins.raw[PIN_DIN]    = din_i;
    assign pins.raw[PIN_CONV]   = conversion_start_n_i;
    assign pins.raw[PIN_MCLK]   = master_clock_in_i;
    assign pins.raw[PIN_SEL_HI] = interface_select_hi_i;
    assign pins.raw[PIN_SEL_LO] = interface_select_lo_i;
    assign pins.raw[PIN_POL]    = polarity_i;

    pin_sampler #(
        .W         (PIN_COUNT),
        .RESET_LVL (PIN_RESET)
    ) u_pins (
        .core_clk_i (core_clk_i),
        .resetn_i   (resetn_i),
        .pins       (pins)
    );

    // ==========================================================
    // State
    xfer_state_t       state_reg, state_next;
    logic [2:0]        mode_reg, mode_next;
    logic [CW-1:0]     cnt_reg, cnt_next;
    logic [WORD_W-1:0] tx_reg, tx_next;
    logic [WORD_W-1:0] rx_reg, rx_next;
    logic [WORD_W-1:0] rxw_reg, rxw_next;
    logic              rxv_reg, rxv_next;
    logic              bit_reg, bit_next;
    logic              dir_out_reg, dir_out_next;
    logic              req_reg, req_next;
    logic              conv_reg, conv_next;
    logic              sclk_reg, sclk_next;
    logic              sync_reg, sync_next;
    logic              din_oe_reg, din_oe_next;
    logic              dout_oe_reg, dout_oe_next;
    logic              master_oe_reg;

    logic pol, slave, master, two_wire, out_edge, samp_edge;
    logic clk_lvl, clk_rise, clk_fall, sync_low, start_slave, load_now, frame_on;

    // ==========================================================
    // Mode decode and edge selection
    always_comb begin
        case ({pins.level[PIN_SEL_HI], pins.level[PIN_SEL_LO]})
            2'b00:   mode_next = two_wire_sel_i ? MODE_1 : MODE_2;
            2'b01:   mode_next = MODE_3;
            2'b10:   mode_next = MODE_4;
            2'b11:   mode_next = MODE_5;
            default: mode_next = MODE_RESET;
        endcase
    end

    assign pol      = pins.level[PIN_POL];
    assign two_wire = (mode_reg == MODE_1);
    assign master   = (mode_reg == MODE_4) || (mode_reg == MODE_5);
    assign slave    = ~master;
    assign clk_lvl  = slave ? pins.level[PIN_SCLK] : pins.level[PIN_MCLK];
    assign clk_rise = slave ? pins.rise[PIN_SCLK] : pins.rise[PIN_MCLK];
    assign clk_fall = slave ? pins.fall[PIN_SCLK] : pins.fall[PIN_MCLK];
    assign sync_low = ~pins.level[PIN_SYNC];

    // Host-clocked modes shift on the rise at select 0, device-clocked on the fall
    assign out_edge  = slave ? (pol ? clk_fall : clk_rise)
                             : (pol ? clk_rise : clk_fall);
    assign samp_edge = slave ? (pol ? clk_rise : clk_fall)
                             : (pol ? clk_fall : clk_rise);

    // MSB goes out at once when the next clock edge is the sampling one
    assign load_now    = pol ? ~clk_lvl : clk_lvl;
    assign start_slave = slave && pins.fall[PIN_SYNC];
    assign frame_on    = (state_next == ST_XFER) || (state_reg == ST_XFER);

    // ==========================================================
    // Transfer sequencer
    always_comb begin
        state_next   = state_reg;
        cnt_next     = cnt_reg;
        tx_next      = tx_reg;
        rx_next      = rx_reg;
        rxw_next     = rxw_reg;
        rxv_next     = 1'b0;
        bit_next     = bit_reg;
        dir_out_next = dir_out_reg;
        req_next     = req_reg;
        sync_next    = sync_reg;
        conv_next    = pins.fall[PIN_CONV] || conv_bit_i;
        case (state_reg)
            ST_IDLE: begin
                if (start_slave) begin
                    // Every frame opens on a clean shifter
                    state_next = ST_XFER;
                    cnt_next   = '0;
                    rx_next    = '0;
                    tx_next    = tx_word_i;
                    if (load_now && !(two_wire && !dir_out_reg)) begin
                        bit_next = tx_word_i[WORD_W-1];
                        tx_next  = tx_word_i << 1;
                    end
                end else if (master && req_reg) begin
                    state_next = ST_WAIT;
                    req_next   = 1'b0;
                end
            end
            ST_WAIT: begin
                // Sync drops on an output edge so the MSB meets a sampling edge
                if (out_edge) begin
                    state_next = ST_XFER;
                    sync_next  = 1'b0;
                    cnt_next   = '0;
                    rx_next    = '0;
                    bit_next   = tx_word_i[WORD_W-1];
                    tx_next    = tx_word_i << 1;
                end
            end
            ST_XFER: begin
                if (out_edge) begin
                    bit_next = tx_reg[WORD_W-1];
                    tx_next  = tx_reg << 1;
                end
                if (samp_edge) begin
                    rx_next  = {rx_reg[WORD_W-2:0], pins.level[PIN_DIN]};
                    cnt_next = CW'(cnt_reg + 1'b1);
                    if (cnt_reg == LAST_BIT) begin
                        cnt_next = '0;
                        rxw_next = {rx_reg[WORD_W-2:0], pins.level[PIN_DIN]};
                        rxv_next = !(two_wire && dir_out_reg);
                        if (two_wire) begin
                            // Shared pin turns around on each word edge; calibration bursts force its direction
                            if (cal_read_burst_i) begin
                                dir_out_next = 1'b1;
                            end else if (cal_write_burst_i) begin
                                dir_out_next = 1'b0;
                            end else begin
                                dir_out_next = ~dir_out_reg;
                            end
                            tx_next = tx_word_i;
                        end else begin
                            // Internal count ends the word; extra clocks do nothing
                            state_next = ST_IDLE;
                            sync_next  = 1'b1;
                        end
                    end
                end
                // Sync rise aborts in level-triggered modes
                if (slave && mode_reg != MODE_3 && !sync_low) begin
                    state_next = ST_IDLE;
                    cnt_next   = '0;
                    rx_next    = '0;
                    tx_next    = '0;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        if (pins.rise[PIN_CONV] || conv_bit_i) begin
            req_next = 1'b1;
        end

        // Mode switch drops any frame in flight
        if (mode_next != mode_reg) begin
            state_next   = ST_IDLE;
            sync_next    = 1'b1;
            dir_out_next = 1'b0;
            cnt_next     = '0;
            req_next     = 1'b0;
        end
    end

    // ==========================================================
    // Pin drive
    always_comb begin
        sclk_next    = 1'b0;
        din_oe_next  = 1'b0;
        dout_oe_next = 1'b0;
        if (master) begin
            // Mode 4 gates the master clock; at select 0 the 16th pulse outlives the frame
            if (mode_reg == MODE_5) begin
                sclk_next = pins.level[PIN_MCLK];
            end else begin
                sclk_next = pins.level[PIN_MCLK] && frame_on;
            end
            dout_oe_next = frame_on;
        end else if (two_wire) begin
            din_oe_next = dir_out_next && sync_low;
        end else begin
            dout_oe_next = sync_low;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_reg   <= ST_IDLE;
            mode_reg    <= MODE_RESET;
            cnt_reg     <= '0;
            tx_reg      <= WORD_RESET[WORD_W-1:0];
            rx_reg      <= WORD_RESET[WORD_W-1:0];
            rxw_reg     <= WORD_RESET[WORD_W-1:0];
            rxv_reg     <= 1'b0;
            bit_reg     <= 1'b0;
            dir_out_reg <= 1'b0;
            req_reg     <= 1'b0;
            conv_reg    <= 1'b0;
            sclk_reg    <= 1'b0;
            sync_reg    <= 1'b1;
            din_oe_reg  <= 1'b0;
            dout_oe_reg <= 1'b0;
        end else begin
            state_reg   <= state_next;
            mode_reg    <= mode_next;
            cnt_reg     <= cnt_next;
            tx_reg      <= tx_next;
            rx_reg      <= rx_next;
            rxw_reg     <= rxw_next;
            rxv_reg     <= rxv_next;
            bit_reg     <= bit_next;
            dir_out_reg <= dir_out_next;
            req_reg     <= req_next;
            conv_reg    <= conv_next;
            sclk_reg    <= sclk_next;
            sync_reg    <= sync_next;
            din_oe_reg  <= din_oe_next;
            dout_oe_reg <= dout_oe_next;
        end
    end

    // ==========================================================
    // Outputs
    assign sclk_o       = sclk_reg;
    assign sclk_oe_o    = master_oe_reg;
    assign sync_n_o     = sync_reg;
    assign sync_n_oe_o  = master_oe_reg;
    assign din_o        = bit_reg;
    assign din_oe_o     = din_oe_reg;
    assign dout_o       = bit_reg;
    assign dout_oe_o    = dout_oe_reg;
    assign rx_word_o    = rxw_reg;
    assign rx_valid_o   = rxv_reg;
    assign conv_start_o = conv_reg;
    assign mode_o       = mode_reg;

    // Device owns clock and sync only in its own clocking modes
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            master_oe_reg <= 1'b0;
        end else begin
            master_oe_reg <= (mode_next == MODE_4) || (mode_next == MODE_5);
        end
    end

endmodule

// ### verification/adc_serial_port_assertions.sv
// Concurrent checks on the converter serial port pins
`timescale 1ns/1ps
module adc_serial_port_assertions
    import adc_serial_port_pkg::*;
(
    input wire logic       core_clk_i,
    input wire logic       resetn_i,
    input wire logic       sync_n_i,
    input wire logic       sclk_o,
    input wire logic       sclk_oe_o,
    input wire logic       sync_n_o,
    input wire logic       sync_n_oe_o,
    input wire logic       din_oe_o,
    input wire logic       dout_oe_o,
    input wire logic       rx_valid_o,
    input wire logic       conv_start_o,
    input wire logic [2:0] mode_o
);
    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!resetn_i);

    // ====
    // Pin ownership
    a_master_sclk_oe: assert property (sclk_oe_o |-> mode_o == MODE_4 || mode_o == MODE_5)
        else $error("serial clock driven outside master modes");
    a_master_sync_oe: assert property (sync_n_oe_o |-> mode_o >= MODE_4)
        else $error("frame sync driven outside master modes");
    a_shared_pin_m1: assert property (din_oe_o |-> mode_o == MODE_1)
        else $error("shared data pin driven outside two-wire mode");
    a_mode_legal: assert property (mode_o >= MODE_1 && mode_o <= MODE_5)
        else $error("mode number out of range");
    // Sampler lag is under eight cycles
    a_dout_float_m2: assert property ((mode_o == MODE_2 && sync_n_i) [*8] |-> !dout_oe_o)
        else $error("data out still driven with sync high");

    // ====
    // Framing and pulses
    a_frame_length: assert property ($fell(sync_n_o) |-> (!sync_n_o) [*8] ##[1:400] sync_n_o)
        else $error("device frame sync low for a wrong span");
    a_gated_clock_m4: assert property ((mode_o == MODE_4 && sync_n_o) [*3] |-> !sclk_o)
        else $error("serial clock runs between frames in gated mode");
    a_rx_one_cycle: assert property ($rose(rx_valid_o) |=> !rx_valid_o)
        else $error("receive strobe longer than one cycle");
    a_conv_one_cycle: assert property (conv_start_o |=> !conv_start_o)
        else $error("conversion start longer than one cycle");

    c_word_m2: cover property (rx_valid_o && mode_o == MODE_2);
    c_word_m3: cover property (rx_valid_o && mode_o == MODE_3);
    c_frame_m4: cover property ($fell(sync_n_o) && mode_o == MODE_4);
    c_conv: cover property (conv_start_o);
endmodule

// ### verification/host_model.sv
// Host serial port model facing the converter port
`timescale 1ns/1ps
module host_model (
    input  wire logic pol_i,
    input  wire logic slave_en_i,
    input  wire logic dev_sclk_i,
    input  wire logic dev_sync_n_i,
    input  wire logic dout_i,
    output logic      sclk_o,
    output logic      sync_n_o,
    output logic      din_o
);
    logic [15:0] word;
    logic [15:0] got;
    int          left;

    initial begin
        sclk_o = 1'b0;
        sync_n_o = 1'b1;
        din_o = 1'b0;
        word = 16'h0000;
        got = 16'h0000;
        left = 0;
    end

    // ====
    // Host as master; idle clock opposite to pol gives sync-fall MSB
    task automatic xfer(input logic [15:0] w, input int n);
        word = w;
        sclk_o = ~pol_i;
        #160;
        din_o = w[15];
        sync_n_o = 1'b0;
        #160;
        for (int i = 15; i > 15 - n; i--) begin
            got = {got[14:0], dout_i};
            sclk_o = pol_i;
            #80;
            sclk_o = ~pol_i;
            if (i > 0) din_o = w[i-1];
            #80;
        end
        sync_n_o = 1'b1;
        // Released line shows the inverse, not a stale bit
        din_o = ~din_o;
    endtask

    // ====
    // Host as slave to the device clock and sync
    // Counts 16 clocks from sync fall; sync and clock may move in one step
    always @(negedge dev_sync_n_i) if (slave_en_i) begin
        left = 16;
        din_o = word[15];
    end
    always @(posedge dev_sync_n_i) if (slave_en_i) din_o = ~din_o;
    always @(posedge dev_sclk_i) if (slave_en_i && left > 0) begin
        got = {got[14:0], dout_i};
        left--;
    end
    always @(negedge dev_sclk_i) if (slave_en_i && left > 0 && left < 16) din_o = word[left-1];
endmodule

// ### verification/adc_multimode_serial_port_bench.sv
// Self-checking bench for the multimode converter serial port
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin failures++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module adc_multimode_serial_port_bench;
    import adc_serial_port_pkg::*;
    logic        clk, rst_n, sel_hi, sel_lo, pol, two_wire, conv_bit, conv_n, mclk, slave_en, cal_wr;
    logic        sclk_o, sclk_oe, sync_o, sync_oe, din_o, din_oe, dout_o, dout_oe, rx_valid, conv_start;
    logic        h_sclk, h_sync, h_din;
    logic [15:0] tx_word, rx_word;
    logic [2:0]  mode;
    int          failures, samples_checked, rx_cnt, conv_cnt;
    wire         sclk_pin = sclk_oe ? sclk_o : h_sclk;
    wire         sync_pin = sync_oe ? sync_o : h_sync;
    wire         din_pin = din_oe ? din_o : h_din;
    wire         dout_pin = dout_oe ? dout_o : ~dout_o;

    adc_serial_port DUT (.core_clk_i(clk), .resetn_i(rst_n), .interface_select_hi_i(sel_hi),
        .interface_select_lo_i(sel_lo), .polarity_i(pol), .two_wire_sel_i(two_wire), .conv_bit_i(conv_bit),
        .conversion_start_n_i(conv_n), .master_clock_in_i(mclk), .cal_read_burst_i(1'b0),
        .cal_write_burst_i(cal_wr), .sclk_i(sclk_pin), .sync_n_i(sync_pin), .din_i(din_pin),
        .tx_word_i(tx_word), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe), .sync_n_o(sync_o), .sync_n_oe_o(sync_oe),
        .din_o(din_o), .din_oe_o(din_oe), .dout_o(dout_o), .dout_oe_o(dout_oe), .rx_word_o(rx_word),
        .rx_valid_o(rx_valid), .conv_start_o(conv_start), .mode_o(mode));
    host_model host (.pol_i(pol), .slave_en_i(slave_en), .dev_sclk_i(sclk_pin), .dev_sync_n_i(sync_pin),
        .dout_i(dout_pin), .sclk_o(h_sclk), .sync_n_o(h_sync), .din_o(h_din));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Link clock offset so it never lines up with the core clock
    initial begin
        mclk = 1'b0;
        #3;
        forever #80 mclk = ~mclk;
    end
    always @(posedge clk) begin
        if (rx_valid === 1'b1) rx_cnt++;
        if (conv_start === 1'b1) conv_cnt++;
    end

    task automatic wrap_up;
        $display("failures=%0d samples_checked=%0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic setm(input logic hi, input logic lo, input logic p, input logic tw);
        @(posedge clk);
        #1;
        sel_hi = hi;
        sel_lo = lo;
        pol = p;
        two_wire = tw;
        repeat (20) @(posedge clk);
        #1;
    endtask

    // ====
    // Host-clocked word exchange
    task automatic s_slave(input logic lo, input logic p, input logic [15:0] hw, input logic [15:0] dw);
        int n;
        setm(1'b0, lo, p, 1'b0);
        tx_word = dw;
        n = rx_cnt;
        host.xfer(hw, 16);
        repeat (10) @(posedge clk);
        `CHK(rx_word, hw)
        `CHK(host.got, dw)
        `CHK(rx_cnt, n + 1)
        `CHK(dout_oe, 1'b0)
        `CHK(mode, lo ? MODE_3 : MODE_2)
    endtask

    task automatic s_abort;
        int n;
        setm(1'b0, 1'b0, 1'b0, 1'b0);
        n = rx_cnt;
        host.xfer(16'hffff, 5);
        host.xfer(TEST_RESTORE_WORD, 16);
        repeat (10) @(posedge clk);
        `CHK(rx_cnt, n + 1)
        `CHK(rx_word, TEST_RESTORE_WORD)
    endtask

    task automatic s_mode1;
        int n;
        setm(1'b0, 1'b0, 1'b0, 1'b1);
        `CHK(mode, MODE_1)
        // Write burst keeps the shared pin an input for both words
        cal_wr = 1'b1;
        n = rx_cnt;
        host.xfer(16'hc0de, 16);
        host.xfer(16'h0bad, 16);
        repeat (10) @(posedge clk);
        #1;
        cal_wr = 1'b0;
        `CHK(rx_cnt, n + 2)
        `CHK(rx_word, 16'h0bad)
        `CHK(din_oe, 1'b0)
        n = conv_cnt;
        conv_bit = 1'b1;
        @(posedge clk);
        #1;
        conv_bit = 1'b0;
        repeat (10) @(posedge clk);
        `CHK(conv_cnt, n + 1)
        conv_n = 1'b0;
        repeat (10) @(posedge clk);
        #1;
        conv_n = 1'b1;
        `CHK(conv_cnt, n + 2)
        setm(1'b0, 1'b1, 1'b0, 1'b1);
        `CHK(mode, MODE_3)
    endtask

    // ====
    // Device-clocked frames, gated then continuous
    task automatic s_master(input logic lo, input logic [15:0] hw, input logic [15:0] dw);
        int n;
        int t;
        logic s;
        setm(1'b1, lo, 1'b0, 1'b0);
        slave_en = 1'b1;
        tx_word = dw;
        host.word = hw;
        n = rx_cnt;
        conv_n = 1'b0;
        repeat (5) @(posedge clk);
        #1;
        conv_n = 1'b1;
        for (int i = 0; i < 1000 && rx_cnt == n; i++) @(posedge clk);
        repeat (40) @(posedge clk);
        `CHK(rx_word, hw)
        `CHK(host.got, dw)
        `CHK(sync_o, 1'b1)
        `CHK(sclk_oe, 1'b1)
        `CHK(mode, lo ? MODE_5 : MODE_4)
        t = 0;
        s = sclk_o;
        repeat (40) begin
            @(posedge clk);
            if (sclk_o !== s) t++;
            s = sclk_o;
        end
        `CHK((t != 0), lo)
        slave_en = 1'b0;
    endtask

    initial begin
        {rst_n, sel_hi, sel_lo, pol, two_wire, conv_bit, slave_en, cal_wr} = 8'h00;
        conv_n = 1'b1;
        tx_word = 16'h0000;
        failures = 0;
        samples_checked = 0;
        rx_cnt = 0;
        conv_cnt = 0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (8) @(posedge clk);
        s_slave(1'b0, 1'b0, 16'ha53c, 16'h3cc5);
        s_slave(1'b0, 1'b1, 16'h8001, 16'h7ffe);
        s_slave(1'b1, 1'b0, 16'h0ff0, 16'hf00f);
        s_slave(1'b1, 1'b1, 16'h1234, 16'hedcb);
        s_abort;
        s_mode1;
        s_master(1'b0, 16'hc3a5, 16'h5a3c);
        s_master(1'b1, 16'h6e11, 16'h91ee);
        wrap_up;
    end

    // Whole run is near 31 us; a hang past 300 us fails
    initial begin
        #300us;
        failures++;
        wrap_up;
    end
endmodule

bind adc_serial_port adc_serial_port_assertions chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .sync_n_i(sync_n_i), .sclk_o(sclk_o), .sclk_oe_o(sclk_oe_o), .sync_n_o(sync_n_o),
    .sync_n_oe_o(sync_n_oe_o), .din_oe_o(din_oe_o), .dout_oe_o(dout_oe_o), .rx_valid_o(rx_valid_o),
    .conv_start_o(conv_start_o), .mode_o(mode_o));
